// File: hw/qime_pkg.sv
package qime_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // command codes and mode byte values
  localparam logic [7:0] CMD_QUAD_OUTPUT_READ = 8'h6b;
  localparam logic [7:0] CMD_QUAD_ADDR_DATA_READ = 8'heb;
  localparam logic [7:0] CMD_QUAD_DATA_WRITE = 8'h32;
  localparam logic [7:0] CMD_QUAD_ADDR_DATA_WRITE = 8'h12;
  localparam logic [7:0] MODE_XIP_SET = 8'hef;
  localparam logic [7:0] MODE_XIP_CLEAR = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // frame layout in link clocks
  localparam logic [5:0] CMD_CLKS = 6'h08;
  localparam logic [5:0] ADDR_SER_CLKS = 6'h18;
  localparam logic [5:0] ADDR_QUAD_CLKS = 6'h06;
  localparam logic [5:0] MODE_CLKS = 6'h02;
  localparam int ADDR_W = 24;
  localparam int MEM_AW = 17;
  localparam int MEM_BYTES = 131072;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int SYS_PERIOD_NS = 8;
  localparam int SCK_MAX_MHZ = 104;
  localparam int SCK_MIN_PERIOD_PS = 1000000 / SCK_MAX_MHZ;
  localparam logic [2:0] HOST_PH_RISE = 3'h4;
  localparam logic [2:0] HOST_PH_LAST = 3'h7;
  localparam int CS_GAP_NS = 50;
  localparam int CS_GAP_CYC = (CS_GAP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam logic [3:0] CS_GAP_CNT = 4'(CS_GAP_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // state encodings
  typedef enum logic [2:0] {
    DS_CMD = 3'b000,
    DS_ADDR = 3'b001,
    DS_MODE = 3'b011,
    DS_RDAT = 3'b010,
    DS_WDAT = 3'b110,
    DS_IGN = 3'b111
  } qime_dev_st_e;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SETUP = 2'b01,
    HS_RUN = 2'b11,
    HS_GAP = 2'b10
  } qime_host_st_e;

  ////////////////////////////////////////////////////////////////////////////
  // command decoding shared by both ends
  function automatic logic cmd_is_read(input logic [7:0] c);
    cmd_is_read = (c == CMD_QUAD_OUTPUT_READ) || (c == CMD_QUAD_ADDR_DATA_READ);
  endfunction

  function automatic logic cmd_quad_addr(input logic [7:0] c);
    cmd_quad_addr = (c == CMD_QUAD_ADDR_DATA_READ) ||
                    (c == CMD_QUAD_ADDR_DATA_WRITE);
  endfunction

  function automatic logic cmd_known(input logic [7:0] c);
    cmd_known = cmd_is_read(c) || (c == CMD_QUAD_DATA_WRITE) ||
                (c == CMD_QUAD_ADDR_DATA_WRITE);
  endfunction

  function automatic logic [5:0] cmd_addr_clks(input logic [7:0] c);
    cmd_addr_clks = cmd_quad_addr(c) ? ADDR_QUAD_CLKS : ADDR_SER_CLKS;
  endfunction

endpackage

// File: hw/qime_if.sv
`timescale 1ns/1ns
// four-lane link; the wire level is worked out from both enables
interface qime_if;
  logic cs_n; // select, low active
  logic sck; // link clock from host
  logic [3:0] h_out; // host lane values
  logic [3:0] h_oe_n; // host lane enables, low drives
  logic [3:0] d_out; // device lane values
  logic [3:0] d_oe_n; // device lane enables, low drives
  logic [3:0] io; // resolved lanes

  // undriven lanes float high, as with a pull-up
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      io[i] = !h_oe_n[i] ? h_out[i] : (!d_oe_n[i] ? d_out[i] : 1'b1);
    end
  end

  modport host (output cs_n, output sck, output h_out, output h_oe_n,
                input io);
  modport device (input cs_n, input sck, input io, output d_out,
                  output d_oe_n);
endinterface

// File: hw/qime_sync3.sv
`timescale 1ns/1ns
// three-stage synchroniser; output follows once stages two and three agree
module qime_sync3 #(
  parameter int W = 1
) (
  input wire logic clk, // destination clock
  input wire logic rst, // sync reset, high
  input wire logic [W-1:0] d, // foreign input
  output logic [W-1:0] q // filtered value
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q;

  // s1 feeds s2 only, so metastability never reaches the compare
  always_comb
  begin
    next_q = (s2 == s3) ? s3 : q;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end
endmodule

// File: hw/qime_device.sv
`timescale 1ns/1ns
// Function
// [RL1] data, output, protect, hold pins become four lanes
// [RL2] 6Bh, serial address, mode 32-33, data 34
// [RL3] read byte leaves as two nibbles
// [RL4] host releases lanes before second mode fall
// [RL5] select low opens, select high closes command
// [RL6] reads continue while clocked with select low
// [RL7] EBh, quad address 8-13, mode 14-15
// [RL8] read data drives all lanes until select high
// [RL9] 32h, serial address, write data from 32
// [RL10] 12h, quad address, nibble pair data
// [RL11] writes store every byte, lanes stay inputs
// [RL12] writes work at top link clock rate
// [RL13] continuation offered for reads only
// [RL14] mode EFh arms continuation, FFh clears it
// [RL15] byte address steps after each data byte
module qime_device (
  input wire logic sys_clk, // user side clock
  input wire logic rst, // user reset, high
  qime_if.device lnk, // quad link, device end
  output logic xip_active, // continuation armed, synced
  output logic frame_active // select low, synced
);

  ////////////////////////////////////////////////////////////////////////////
  // link side state, all but continuation and memory cleared by select high since the clock stops then
  qime_pkg::qime_dev_st_e state;
  qime_pkg::qime_dev_st_e next_state;
  qime_pkg::qime_dev_st_e cur;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic [7:0] cmd;
  logic [7:0] next_cmd;
  logic [7:0] cmd_e;
  logic [7:0] sh;
  logic [7:0] next_sh;
  logic [7:0] mode_byte;
  logic [23:0] addr;
  logic [23:0] next_addr;
  logic half;
  logic next_half;
  logic [3:0] nib;
  logic [3:0] next_nib;
  logic mem_we;
  logic execute_in_place;
  logic next_xip;
  logic [7:0] xip_cmd;
  logic [7:0] next_xip_cmd;
  logic [7:0] mem [0:qime_pkg::MEM_BYTES-1];
  logic [7:0] rd_byte;
  logic [qime_pkg::MEM_AW-1:0] widx;
  logic [3:0] d_out;
  logic [3:0] next_d_out;
  logic [3:0] d_oe_n;
  logic [3:0] next_d_oe_n;

  assign widx = addr[qime_pkg::MEM_AW-1:0];
  assign rd_byte = mem[widx];
  assign mode_byte = {sh[3:0], lnk.io};
  assign lnk.d_out = d_out;
  assign lnk.d_oe_n = d_oe_n;

  ////////////////////////////////////////////////////////////////////////////
  // rising edge: sample lanes, walk the frame
  // an armed continuation skips the code and reuses the last read command
  always_comb
  begin
    cur = state;
    cmd_e = cmd;
    if (state == qime_pkg::DS_CMD && execute_in_place)
    begin
      cur = qime_pkg::DS_ADDR; // [RL13]
      cmd_e = xip_cmd;
    end
    next_state = cur;
    next_cnt = cnt + 6'h01;
    next_cmd = cmd_e;
    next_sh = sh;
    next_addr = addr;
    next_half = half;
    next_nib = nib;
    next_xip = execute_in_place;
    next_xip_cmd = xip_cmd;
    mem_we = 1'b0;
    unique case (cur)
      qime_pkg::DS_CMD:
      begin
        // code arrives on lane 0 only
        next_sh = {sh[6:0], lnk.io[0]}; // [RL5]
        if (cnt == qime_pkg::CMD_CLKS - 6'h01)
        begin
          next_cmd = next_sh;
          next_cnt = 6'h00;
          // unknown codes are ignored until select rises
          next_state = qime_pkg::cmd_known(next_sh) ? qime_pkg::DS_ADDR :
                       qime_pkg::DS_IGN;
        end
      end
      qime_pkg::DS_ADDR:
      begin
        if (qime_pkg::cmd_quad_addr(cmd_e))
        begin
          next_addr = {addr[19:0], lnk.io}; // [RL7] [RL10] [RL1]
        end
        else
        begin
          next_addr = {addr[22:0], lnk.io[0]}; // [RL2] [RL9]
        end
        if (cnt == qime_pkg::cmd_addr_clks(cmd_e) - 6'h01)
        begin
          next_cnt = 6'h00;
          next_half = 1'b0;
          // writes have no mode byte
          next_state = qime_pkg::cmd_is_read(cmd_e) ? qime_pkg::DS_MODE :
                       qime_pkg::DS_WDAT; // [RL13]
        end
      end
      qime_pkg::DS_MODE:
      begin
        next_sh = mode_byte;
        if (cnt == qime_pkg::MODE_CLKS - 6'h01)
        begin
          next_cnt = 6'h00;
          next_half = 1'b0;
          next_state = qime_pkg::DS_RDAT; // [RL2] [RL7]
          // any value but the arm code drops continuation
          if (mode_byte == qime_pkg::MODE_XIP_SET)
          begin
            next_xip = 1'b1; // [RL14]
            next_xip_cmd = cmd_e;
          end
          else
          begin
            next_xip = 1'b0; // [RL14]
          end
        end
      end
      qime_pkg::DS_RDAT:
      begin
        // no end count: runs as long as the host clocks
        next_cnt = cnt;
        next_half = !half; // [RL6]
        if (half)
        begin
          next_addr = addr + 24'h000001; // [RL15]
        end
      end
      qime_pkg::DS_WDAT:
      begin
        next_cnt = cnt;
        next_nib = lnk.io;
        next_half = !half;
        if (half)
        begin
          mem_we = 1'b1; // [RL11]
          next_addr = addr + 24'h000001; // [RL15]
        end
      end
      qime_pkg::DS_IGN:
      begin
        next_cnt = cnt;
      end
    endcase
  end

  always_ff @(posedge lnk.sck or posedge lnk.cs_n)
  begin
    if (lnk.cs_n)
    begin
      state <= qime_pkg::DS_CMD; // [RL5]
      cnt <= 6'h00;
      cmd <= 8'h00;
      sh <= 8'h00;
      addr <= 24'h000000;
      half <= 1'b0;
      nib <= 4'h0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      cmd <= next_cmd;
      sh <= next_sh;
      addr <= next_addr;
      half <= next_half;
      nib <= next_nib;
    end
  end

  // continuation survives select high; user reset or a mode byte other than the arm code clears it
  always_ff @(posedge lnk.sck or posedge rst)
  begin
    if (rst)
    begin
      execute_in_place <= 1'b0;
      xip_cmd <= 8'h00;
    end
    else
    begin
      execute_in_place <= next_xip;
      xip_cmd <= next_xip_cmd;
    end
  end

  // one write per byte on the closing nibble edge; nothing waits on a
  // second edge, so the write path holds at the top link rate
  always_ff @(posedge lnk.sck)
  begin
    if (mem_we)
    begin
      mem[widx] <= {nib, lnk.io}; // [RL11] [RL12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // falling edge: launch read nibbles, high half first
  // drive starts at the fall of the last mode clock, after the host let go
  always_comb
  begin
    next_d_out = half ? rd_byte[3:0] : rd_byte[7:4]; // [RL3]
    next_d_oe_n = 4'hf; // [RL11]
    if (state == qime_pkg::DS_RDAT)
    begin
      next_d_oe_n = 4'h0; // [RL8] [RL4]
    end
  end

  always_ff @(negedge lnk.sck or posedge lnk.cs_n)
  begin
    if (lnk.cs_n)
    begin
      d_out <= 4'h0;
      d_oe_n <= 4'hf; // [RL8]
    end
    else
    begin
      d_out <= next_d_out;
      d_oe_n <= next_d_oe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status levels toward the user clock
  qime_sync3 #(
    .W(2)
  ) u_sync (
    .clk(sys_clk),
    .rst(rst),
    .d({execute_in_place, !lnk.cs_n}),
    .q({xip_active, frame_active})
  );

endmodule

// File: hw/qime_host.sv
`timescale 1ns/1ns
// host end: makes the link clock by dividing sys_clk by eight
module qime_host (
  input wire logic sys_clk, // system clock
  input wire logic rst, // sync reset, high
  qime_if.host lnk, // quad link, host end
  input wire logic start, // begin a command, pulse
  input wire logic [7:0] cmd, // command code
  input wire logic [23:0] addr, // start byte address
  input wire logic [7:0] mode, // mode byte for reads
  input wire logic [15:0] nbytes, // data bytes to move
  input wire logic skip_cmd, // continuation: omit code
  input wire logic [7:0] wr_data, // write byte, held ready
  output logic wr_take, // wr_data taken, pulse
  output logic [7:0] rd_data, // read byte
  output logic rd_valid, // rd_data new, pulse
  output logic busy, // command in progress
  output logic done // command closed, pulse
);
  qime_pkg::qime_host_st_e state;
  qime_pkg::qime_host_st_e next_state;
  logic [2:0] ph;
  logic [2:0] next_ph;
  logic [5:0] n;
  logic [5:0] next_n;
  logic [5:0] dstart;
  logic [39:0] hsh;
  logic [39:0] next_hsh;
  logic [7:0] c;
  logic [7:0] next_c;
  logic [15:0] left;
  logic [15:0] next_left;
  logic dhalf;
  logic next_dhalf;
  logic [7:0] wbyte;
  logic [7:0] next_wbyte;
  logic [3:0] rhi;
  logic [3:0] next_rhi;
  logic [7:0] next_rd_data;
  logic next_rd_valid;
  logic next_done;
  logic [3:0] next_out;
  logic [3:0] next_oe_n;
  logic next_sck;
  logic next_cs_n;
  logic [3:0] lane_in;
  logic rd;
  logic ser;
  logic adv;

  assign rd = qime_pkg::cmd_is_read(c);
  assign dstart = qime_pkg::CMD_CLKS + qime_pkg::cmd_addr_clks(c) +
                  (rd ? qime_pkg::MODE_CLKS : 6'h00);
  assign ser = (n < qime_pkg::CMD_CLKS) || !qime_pkg::cmd_quad_addr(c) &&
               (n < qime_pkg::CMD_CLKS + qime_pkg::ADDR_SER_CLKS);
  assign adv = (state == qime_pkg::HS_RUN) && (ph == qime_pkg::HOST_PH_LAST);
  assign busy = (state != qime_pkg::HS_IDLE);

  qime_sync3 #(
    .W(4)
  ) u_sync (
    .clk(sys_clk),
    .rst(rst),
    .d(lnk.io),
    .q(lane_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer; lanes change with the falling clock, read sampled late
  always_comb
  begin
    next_state = state;
    next_ph = ph + 3'h1;
    next_n = n;
    next_hsh = hsh;
    next_c = c;
    next_left = left;
    next_dhalf = dhalf;
    next_wbyte = wbyte;
    next_rhi = rhi;
    next_rd_data = rd_data;
    next_rd_valid = 1'b0;
    next_done = 1'b0;
    wr_take = 1'b0;
    unique case (state)
      qime_pkg::HS_IDLE:
      begin
        next_ph = 3'h0;
        if (start)
        begin
          next_state = qime_pkg::HS_SETUP;
          next_c = cmd;
          next_left = nbytes;
          next_dhalf = 1'b0;
          next_n = skip_cmd ? qime_pkg::CMD_CLKS : 6'h00; // [RL14]
          next_hsh = skip_cmd ? {addr, mode, 8'h00} : {cmd, addr, mode};
        end
      end
      qime_pkg::HS_SETUP:
      begin
        if (ph == qime_pkg::HOST_PH_LAST)
        begin
          next_state = qime_pkg::HS_RUN;
        end
      end
      qime_pkg::HS_RUN:
      begin
        if (adv && n < dstart)
        begin
          next_hsh = ser ? {hsh[38:0], 1'b0} : {hsh[35:0], 4'h0};
          next_n = n + 6'h01;
          if (next_n == dstart && left == 16'h0000)
          begin
            next_state = qime_pkg::HS_GAP;
          end
        end
        else if (adv)
        begin
          next_dhalf = !dhalf;
          if (rd && !dhalf)
          begin
            next_rhi = lane_in;
          end
          else if (rd)
          begin
            next_rd_data = {rhi, lane_in};
            next_rd_valid = 1'b1;
          end
          if (dhalf)
          begin
            next_left = left - 16'h0001;
            if (left == 16'h0001)
            begin
              next_state = qime_pkg::HS_GAP;
            end
          end
        end
        if (next_state == qime_pkg::HS_GAP)
        begin
          next_ph = 3'h0;
          next_n = 6'h00; // gap counter starts from zero
        end
        else if (adv && !rd && next_n == dstart && !next_dhalf)
        begin
          wr_take = 1'b1;
          next_wbyte = wr_data;
        end
      end
      qime_pkg::HS_GAP:
      begin
        next_ph = ph;
        next_n = n + 6'h01; // [RL5]
        if (n[3:0] == qime_pkg::CS_GAP_CNT)
        begin
          next_state = qime_pkg::HS_IDLE;
          next_done = 1'b1;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin values for the coming cycle, all from flops
  always_comb
  begin
    next_cs_n = !(next_state == qime_pkg::HS_SETUP || // [RL5]
                  next_state == qime_pkg::HS_RUN);
    next_sck = (next_state == qime_pkg::HS_RUN) &&
               (next_ph >= qime_pkg::HOST_PH_RISE);
    next_out = 4'h0;
    next_oe_n = 4'hf;
    if (next_state == qime_pkg::HS_RUN && next_n < dstart)
    begin
      if (next_n < qime_pkg::CMD_CLKS || !qime_pkg::cmd_quad_addr(next_c) &&
          next_n < qime_pkg::CMD_CLKS + qime_pkg::ADDR_SER_CLKS)
      begin
        next_out = {3'h0, next_hsh[39]}; // [RL2] [RL9]
        next_oe_n = 4'he;
      end
      else
      begin
        next_out = next_hsh[39:36]; // [RL7] [RL10] [RL1]
        next_oe_n = 4'h0;
        // let go one cycle after the last mode clock rises
        if (rd && next_n == dstart - 6'h01 &&
            next_ph > qime_pkg::HOST_PH_RISE)
        begin
          next_oe_n = 4'hf; // [RL4]
        end
      end
    end
    else if (next_state == qime_pkg::HS_RUN && !rd)
    begin
      next_out = next_dhalf ? next_wbyte[3:0] : next_wbyte[7:4]; // [RL10]
      next_oe_n = 4'h0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state <= qime_pkg::HS_IDLE;
      ph <= 3'h0;
      n <= 6'h00;
      hsh <= 40'h0000000000;
      c <= 8'h00;
      left <= 16'h0000;
      dhalf <= 1'b0;
      wbyte <= 8'h00;
      rhi <= 4'h0;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      done <= 1'b0;
      lnk.cs_n <= 1'b1;
      lnk.sck <= 1'b0;
      lnk.h_out <= 4'h0;
      lnk.h_oe_n <= 4'hf;
    end
    else
    begin
      state <= next_state;
      ph <= next_ph;
      n <= next_n;
      hsh <= next_hsh;
      c <= next_c;
      left <= next_left;
      dhalf <= next_dhalf;
      wbyte <= next_wbyte;
      rhi <= next_rhi;
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      done <= next_done;
      lnk.cs_n <= next_cs_n;
      lnk.sck <= next_sck;
      lnk.h_out <= next_out;
      lnk.h_oe_n <= next_oe_n;
    end
  end
endmodule

// File: tb/qime_asserts.sv
`timescale 1ns/1ns
// link watcher; sees the resolved lanes and both ends' values and enables, clocked by the host's sys_clk
module qime_asserts (
  input wire logic sys_clk, // system clock
  input wire logic rst, // sync reset, high
  input wire logic cs_n, // select, low active
  input wire logic sck, // link clock
  input wire logic [3:0] h_out, // host lane values
  input wire logic [3:0] h_oe_n, // host enables, low drives
  input wire logic [3:0] d_out, // device lane values
  input wire logic [3:0] d_oe_n, // device enables, low drives
  input wire logic [3:0] io // resolved lanes
);
  logic sck_q;
  logic next_sck_q;
  logic [7:0] rises;
  logic [7:0] next_rises;
  logic [7:0] code;
  logic [7:0] next_code;

  ////////////////////////////////////////////////////////////////////////////
  // count link clock rises per frame and catch the code from lane 0
  // continuation frames carry no code, so keep their addresses low
  always_comb
  begin
    next_sck_q = sck;
    next_rises = rises;
    next_code = code;
    if (cs_n)
    begin
      next_rises = 8'h00;
      next_code = 8'h00;
    end
    else if (sck && !sck_q && rises != 8'hff)
    begin
      next_rises = rises + 8'h01;
      if (rises < 8'h08)
        next_code = {code[6:0], io[0]};
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sck_q <= 1'b0;
      rises <= 8'h00;
      code <= 8'h00;
    end
    else
    begin
      sck_q <= next_sck_q;
      rises <= next_rises;
      code <= next_code;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // turnaround of the lanes for both reads
  property p_quiet(logic [7:0] c, logic [7:0] n);
    (code == c && rises > 8'h07 && rises < n && !cs_n) |-> d_oe_n == 4'hf;
  endproperty

  AST_IDLE_SCK_LOW: assert property (cs_n |-> !sck)
    else $error("link clock moves outside a frame");
  AST_IDLE_DEV_OFF: assert property (cs_n |-> d_oe_n == 4'hf)
    else $error("device drives with select high");
  AST_NO_FIGHT: assert property ((h_oe_n | d_oe_n) == 4'hf)
    else $error("host and device drive a lane together");
  AST_ALL_LANES: assert property (d_oe_n == 4'h0 || d_oe_n == 4'hf)
    else $error("device drives only some lanes");
  AST_DRIVE_HOLD: assert property
    ((!cs_n && d_oe_n == 4'h0) ##1 !cs_n |-> d_oe_n == 4'h0)
    else $error("device let go of lanes inside a read");
  AST_DRIVE_AT_FALL: assert property ($fell(d_oe_n[0]) |-> $fell(sck))
    else $error("lane 0 turned round off a clock fall");
  AST_NIBBLE_AT_FALL: assert property
    ((!cs_n && d_oe_n == 4'h0 && !$stable(d_out)) |-> $fell(sck))
    else $error("read nibble changed off a clock fall");
  AST_HOST_HOLD: assert property (sck |-> $stable(h_out))
    else $error("host lanes changed while clock high");
  AST_SCK_SHAPE: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("link clock high time wrong");
  AST_WRITE_INPUTS: assert property
    ((rises > 8'h07 && (code == qime_pkg::CMD_QUAD_DATA_WRITE ||
      code == qime_pkg::CMD_QUAD_ADDR_DATA_WRITE)) |-> d_oe_n == 4'hf)
    else $error("device drove a lane in a write");
  AST_RD6B_QUIET: assert property
    (p_quiet(qime_pkg::CMD_QUAD_OUTPUT_READ, 8'h22))
    else $error("quad output read drove early");
  AST_RD6B_DRIVE: assert property
    ((code == qime_pkg::CMD_QUAD_OUTPUT_READ && rises == 8'h23)
      |-> d_oe_n == 4'h0)
    else $error("quad output read not driving at clock 34");
  AST_RDEB_QUIET: assert property
    (p_quiet(qime_pkg::CMD_QUAD_ADDR_DATA_READ, 8'h10))
    else $error("quad address read drove early");
  AST_RDEB_DRIVE: assert property
    ((code == qime_pkg::CMD_QUAD_ADDR_DATA_READ && rises == 8'h11)
      |-> d_oe_n == 4'h0)
    else $error("quad address read not driving at clock 16");

  // main frame kinds reach their data phase
  cover property (code == qime_pkg::CMD_QUAD_OUTPUT_READ && rises == 8'h23);
  cover property (code == qime_pkg::CMD_QUAD_ADDR_DATA_READ && rises == 8'h11);
  cover property (code == qime_pkg::CMD_QUAD_DATA_WRITE && rises == 8'h28);
  cover property (code == qime_pkg::CMD_QUAD_ADDR_DATA_WRITE && rises == 8'h10);
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic sys_clk = 1'b0;
  logic rst = 1'b0;
  logic start = 1'b0;
  logic [7:0] cmd = 8'h00;
  logic [23:0] addr = 24'h000000;
  logic [7:0] mode = 8'hff;
  logic [15:0] nbytes = 16'h0000;
  logic skip_cmd = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic wr_take;
  logic [7:0] rd_data;
  logic rd_valid;
  logic busy;
  logic done;
  logic xip_active;
  logic frame_active;
  logic [7:0] wbuf [0:15];
  logic [7:0] ref_mem [0:255];
  logic [7:0] rq [$];
  int widx = 0;
  logic took = 1'b0;
  int fails = 0;
  int checks = 0;

  qime_if lnk();

  qime_host i_qime_host (.sys_clk(sys_clk), .rst(rst), .lnk(lnk),
    .start(start), .cmd(cmd), .addr(addr), .mode(mode), .nbytes(nbytes),
    .skip_cmd(skip_cmd), .wr_data(wr_data), .wr_take(wr_take),
    .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy), .done(done));

  qime_device i_qime_device (.sys_clk(sys_clk), .rst(rst), .lnk(lnk),
    .xip_active(xip_active), .frame_active(frame_active));

  qime_asserts i_qime_asserts (.sys_clk(sys_clk), .rst(rst),
    .cs_n(lnk.cs_n), .sck(lnk.sck), .h_out(lnk.h_out),
    .h_oe_n(lnk.h_oe_n), .d_out(lnk.d_out), .d_oe_n(lnk.d_oe_n),
    .io(lnk.io));

  always #4 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  // user side: next write byte only after the host's edge took the current
  // one, since wr_data must stand through the whole take cycle
  // done at the falling edge so nothing races the host's flops
  always @(negedge sys_clk)
  begin
    if (took)
    begin
      widx = widx + 1;
      wr_data = wbuf[widx[3:0]];
    end
    took = (wr_take === 1'b1);
    if (rd_valid === 1'b1)
      rq.push_back(rd_data);
  end

  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp,
                        input string what);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask

  // one host command, waited for under a bounded count
  task automatic run_cmd(input logic [7:0] c, input logic [23:0] a,
                         input logic [7:0] m, input int n, input logic skp);
    int i;
    @(negedge sys_clk);
    cmd = c;
    addr = a;
    mode = m;
    nbytes = 16'(n);
    skip_cmd = skp;
    widx = 0;
    wr_data = wbuf[0];
    rq.delete();
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    check8({7'h00, frame_active | busy}, 8'h01, "command not taken");
    i = 0;
    while (done !== 1'b1 && i < 3000)
    begin
      @(negedge sys_clk);
      i++;
    end
    if (i >= 3000)
    begin
      fails++;
      $display("CHECK FAILED at %0t: command never closed", $time);
      wrap_up();
    end
  endtask

  task automatic do_write(input logic [7:0] c, input logic [23:0] a,
                          input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++)
    begin
      wbuf[i] = base + 8'(i) * 8'h25;
      ref_mem[8'(a + 24'(i))] = wbuf[i];
    end
    run_cmd(c, a, 8'hff, n, 1'b0);
    check8(8'(widx), 8'(n), "write bytes taken");
  endtask

  // read back and compare against what was stored
  task automatic do_read(input logic [7:0] c, input logic [23:0] a,
                         input logic [7:0] m, input int n, input logic skp);
    run_cmd(c, a, m, n, skp);
    check8(8'(rq.size()), 8'(n), "read byte count");
    for (int i = 0; i < n && i < rq.size(); i++)
      check8(rq[i], ref_mem[8'(a + 24'(i))], "read byte");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial
  begin
    // raised as an update so the link-side async clear sees the edge
    rst <= 1'b1;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    check8({7'h00, busy}, 8'h00, "busy after reset");
    check8({4'h0, lnk.d_oe_n}, 8'h0f, "lanes after reset");
    $display("test reset done");
    do_write(qime_pkg::CMD_QUAD_DATA_WRITE, 24'h000010, 8, 8'h5a);
    do_write(qime_pkg::CMD_QUAD_ADDR_DATA_WRITE, 24'h000018, 8, 8'hc3);
    check8({7'h00, xip_active}, 8'h00, "writes left continuation");
    // unknown code must leave memory alone; the reads below prove it
    run_cmd(8'h99, 24'h000010, 8'hff, 2, 1'b0);
    $display("test writes done");
    do_read(qime_pkg::CMD_QUAD_OUTPUT_READ, 24'h000010, 8'hff, 16, 1'b0);
    do_read(qime_pkg::CMD_QUAD_ADDR_DATA_READ, 24'h000012, 8'hff, 14, 1'b0);
    do_read(qime_pkg::CMD_QUAD_ADDR_DATA_READ, 24'h00001f, 8'hff, 1, 1'b0);
    $display("test reads done");
    for (int k = 0; k < 2; k++)
    begin
      cmd = k[0] ? qime_pkg::CMD_QUAD_ADDR_DATA_READ
                 : qime_pkg::CMD_QUAD_OUTPUT_READ;
      do_read(cmd, 24'h000014, qime_pkg::MODE_XIP_SET, 2, 1'b0);
      check8({7'h00, xip_active}, 8'h01, "continuation armed");
      do_read(cmd, 24'h000016, qime_pkg::MODE_XIP_CLEAR, 3, 1'b1);
      check8({7'h00, xip_active}, 8'h00, "continuation cleared");
    end
    $display("test continuation done");
    do_write(qime_pkg::CMD_QUAD_DATA_WRITE, 24'h00001e, 4, 8'h81);
    do_read(qime_pkg::CMD_QUAD_ADDR_DATA_READ, 24'h00001c, 8'hff, 6, 1'b0);
    $display("test overwrite done");
    wrap_up();
  end
endmodule
